// File: bench/swp_host_model.sv
// behavioural host driving the three-wire port
`timescale 1ns/1ps
`default_nettype none
module swp_host_model (
    // serial link
    output var logic link_clk,
    output var logic port_en,
    output var logic ser_din,
    input wire logic ser_cout
);
    logic [47:0] rd_bits;
    logic        loop_r;
    initial begin
        link_clk = 1'b0;
        port_en = 1'b0;
        ser_din = 1'b0;
        loop_r = 1'b0;
        rd_bits = '0;
    end
    ////////////////////////////////////////
    // released line carries cout
    always @(ser_cout) begin
        if (loop_r)
            ser_din = ser_cout;
    end
    task automatic frame(input logic [95:0] bits, input int n,
                         input bit en, input bit loop);
        port_en = en;
        loop_r = loop;
        if (loop)
            ser_din = ser_cout;
        #50;
        for (int k = 0; k < n; k++) begin
            if (!loop)
                ser_din = bits[k];
            #32;
            if (k < 48)
                rd_bits[k] = ser_cout;
            link_clk = 1'b1;
            #32;
            link_clk = 1'b0;
        end
        // 52 keeps the enable fall off the system clock's rising edge
        #52;
        port_en = 1'b0;
        loop_r = 1'b0;
        // a released line must not keep its last level
        ser_din = ~ser_din;
        #130;
    endtask : frame
endmodule : swp_host_model
`default_nettype wire

// File: bench/swp_serial_port_sva.sv
// assertion checker for the wiper serial port
`timescale 1ns/1ps
`default_nettype none
module swp_serial_port_sva (
    // clocks and reset
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        link_clk,
    // serial link
    input wire logic        port_en,
    input wire logic        ser_din,
    input wire logic        ser_cout,
    // wiper side
    input wire logic        apply_hold,
    input wire logic [35:0] wiper_pos,
    input wire logic        apply_busy,
    input wire logic        frame_len_err
);
    logic [47:0] sh_r;
    logic [5:0]  cnt_r;
    logic [5:0]  cnt0_r;
    logic [35:0] exp_w;
    ////////////////////////////////////////
    // shadow of the shift register, link side
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            sh_r <= '0;
            cnt_r <= '0;
        end else if (port_en) begin
            sh_r <= {ser_din, sh_r[47:1]};
            cnt_r <= (cnt_r == 6'h2f) ? 6'h00 : cnt_r + 6'h01;
        end
    end
    // cnt_r only moves while port_en is high, so the count is safe to take while disabled
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            cnt0_r <= '0;
        else if (!port_en)
            cnt0_r <= cnt_r;
    end
    for (genvar i = 0; i < 6; i++) begin : g_exp
        assign exp_w[6*i +: 6] = (sh_r[8*i+6 +: 2] == 2'h3) ?
                                 wiper_pos[6*i +: 6] : sh_r[8*i +: 6];
    end
    ////////////////////////////////////////
    property p_cout;
        @(posedge link_clk) disable iff (!reset_n) ser_cout == sh_r[0];
    endproperty
    a_cout: assert property (p_cout)
        else $error("cascade bit wrong");
    // enable low at two system edges means no link edge shifted between
    property p_idle;
        @(posedge clk_sys) disable iff (!reset_n)
        !port_en && !$past(port_en) |-> $stable(ser_cout);
    endproperty
    a_idle: assert property (p_idle)
        else $error("shift while disabled");
    property p_wiper;
        @(posedge clk_sys) disable iff (!reset_n || apply_hold)
        $fell(port_en) |-> ##[1:24] wiper_pos == exp_w;
    endproperty
    a_wiper: assert property (p_wiper)
        else $error("wipers not applied");
    property p_err;
        logic e;
        @(posedge clk_sys) disable iff (!reset_n)
        ($fell(port_en), e = (cnt_r != cnt0_r)) |-> ##12 frame_len_err == e;
    endproperty
    a_err: assert property (p_err)
        else $error("length flag wrong");
    property p_busy;
        @(posedge clk_sys) disable iff (!reset_n)
        $fell(port_en) |-> ##[2:8] apply_busy;
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy missing");
    property p_quiet;
        @(posedge clk_sys) disable iff (!reset_n)
        !apply_busy [*3] |-> $stable(wiper_pos);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("wiper moved idle");
    property p_rst;
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(reset_n) |-> wiper_pos == '0 && !apply_busy && !frame_len_err;
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset state wrong");
    property p_stall;
        @(posedge clk_sys) disable iff (!reset_n)
        apply_hold [*2] |-> $stable(wiper_pos);
    endproperty
    a_stall: assert property (p_stall)
        else $error("update while held");
    c_frame: cover property (@(posedge clk_sys) $fell(port_en));
    c_held: cover property (@(posedge clk_sys) apply_busy && apply_hold);
    c_err: cover property (@(posedge clk_sys) $rose(frame_len_err));
endmodule : swp_serial_port_sva
bind swp_serial_port swp_serial_port_sva i_sva (
    .clk_sys(clk_sys), .reset_n(reset_n), .link_clk(link_clk),
    .port_en(port_en), .ser_din(ser_din), .ser_cout(ser_cout),
    .apply_hold(apply_hold), .wiper_pos(wiper_pos),
    .apply_busy(apply_busy), .frame_len_err(frame_len_err));
`default_nettype wire

// File: bench/test_swp_serial_port.sv
// self-checking bench for the wiper serial port
`timescale 1ns/1ps
`default_nettype none
module test_swp_serial_port;
    logic        clk_sys;
    logic        reset_n;
    logic        link_clk;
    logic        port_en;
    logic        ser_din;
    logic        ser_cout;
    logic        apply_hold;
    logic [35:0] wiper_pos;
    logic        apply_busy;
    logic        frame_len_err;
    logic [47:0] sr_m;
    logic [35:0] wp_m;
    logic [35:0] wp_o;
    logic [95:0] bits;
    int          seed;
    int          bad_count;
    int          total_checks;
    int          cyc;
    swp_serial_port #(.FIFO_DEPTH(16)) i_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .link_clk(link_clk),
        .port_en(port_en), .ser_din(ser_din), .ser_cout(ser_cout),
        .apply_hold(apply_hold), .wiper_pos(wiper_pos),
        .apply_busy(apply_busy), .frame_len_err(frame_len_err));
    swp_host_model i_host (.link_clk(link_clk), .port_en(port_en),
        .ser_din(ser_din), .ser_cout(ser_cout));
    ////////////////////////////////////////
    function automatic logic [47:0] shift(input logic [47:0] s,
                                          input logic [95:0] b, input int n);
        for (int k = 0; k < n; k++)
            s = {b[k], s[47:1]};
        return s;
    endfunction : shift
    function automatic logic [35:0] apply(input logic [35:0] w,
                                          input logic [47:0] s);
        for (int i = 0; i < 6; i++)
            if (s[8*i+6 +: 2] != 2'h3)
                w[6*i +: 6] = s[8*i +: 6];
        return w;
    endfunction : apply
    task automatic chk(input string nm, input logic [47:0] e, g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic settle;
        repeat (4) @(negedge clk_sys);
        for (int t = 0; t < 40 && apply_busy !== 1'b0; t++)
            @(negedge clk_sys);
    endtask : settle
    task automatic run(input int n, input bit en, input bit loop);
        wp_o = wp_m;
        i_host.frame(bits, n, en, loop);
        if (en && !loop)
            sr_m = shift(sr_m, bits, n);
        if (en)
            wp_m = apply(wp_m, sr_m);
        settle();
        if (apply_hold)
            return;
        chk("wiper", 48'(wp_m), 48'(wiper_pos));
        chk("len_err", 48'(en && n % 48 != 0), 48'(frame_len_err));
        if (loop)
            chk("readback", sr_m, i_host.rd_bits);
    endtask : run
    task automatic results;
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // whole run is about eight thousand cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        seed = 23;
        reset_n = 1'b0;
        apply_hold = 1'b0;
        sr_m = '0;
        wp_m = '0;
        bits = '0;
        repeat (20) @(negedge clk_sys);
        reset_n = 1'b1;
        @(negedge clk_sys);
        chk("reset", 48'(wp_m), 48'(wiper_pos));
        for (int f = 0; f < 12; f++) begin
            bits = {$random(seed), $random(seed), $random(seed)};
            if (f == 0)
                bits[47:0] = 48'h3f3f_3f3f_3f3f;
            if (f == 1)
                bits[47:0] = 48'hffff_ffff_ff00;
            if (f == 2)
                bits[47:0] = 48'h9a5b_9a5b_9a5b;
            run(48, 1'b1, 1'b0);
        end
        run(48, 1'b1, 1'b1);
        bits = {$random(seed), $random(seed), $random(seed)};
        run(48, 1'b0, 1'b0);
        run(48, 1'b1, 1'b1);
        run(20, 1'b1, 1'b0);
        bits = {$random(seed), $random(seed), $random(seed)};
        run(96, 1'b1, 1'b0);
        apply_hold = 1'b1;
        bits = {$random(seed), $random(seed), $random(seed)};
        run(48, 1'b1, 1'b0);
        chk("stall", 48'(wp_o), 48'(wiper_pos));
        chk("busy", 48'h1, 48'(apply_busy));
        apply_hold = 1'b0;
        settle();
        chk("held", 48'(wp_m), 48'(wiper_pos));
        results();
    end
endmodule : test_swp_serial_port
`default_nettype wire

// File: core/swp_fifo.sv
// synchronous fifo in flip-flops with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module swp_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wr_r;
    logic [AW:0]      rd_r;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("swp_fifo: DEPTH must be a power of two, at least 2");
        end
        if (WIDTH < 1) begin
            $error("swp_fifo: WIDTH must be at least 1");
        end
    end

    assign empty     = (wr_r == rd_r);
    assign full      = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;
    assign out_data  = mem_r[rd_r[AW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            wr_r <= wr_r + (AW+1)'(push);
            rd_r <= rd_r + (AW+1)'(pop);
        end
    end

endmodule : swp_fifo

`default_nettype wire

// File: core/swp_pkg.sv
// shared constants for the six-channel wiper serial port
package swp_pkg;

    // shift register and wiper word layout
    localparam int          SR_BITS    = 48;
    localparam int          CH_NUM     = 6;
    localparam int          WORD_BITS  = 8;
    localparam int          POS_BITS   = 6;
    localparam int          POS_LSB    = 0;
    localparam int          KEEP_LSB   = 6;
    localparam int          CH_BITS    = 3;
    localparam logic [1:0]  KEEP_CODE  = 2'h3;

    // values after reset
    localparam logic [POS_BITS-1:0] POS_RESET = 6'h00;
    localparam logic [SR_BITS-1:0]  SR_RESET  = 48'h0000_0000_0000;

    // frame bit counter wraps at one device's worth of bits
    localparam logic [5:0]  BIT_LAST   = 6'h2f;

    // buffer between snapshot and wiper update
    localparam int          FIFO_DEPTH = 16;
    localparam int          FIFO_WIDTH = CH_BITS + WORD_BITS;

    // loader states
    typedef enum logic [1:0] {
        SWP_LD_IDLE = 2'b01,
        SWP_LD_PUSH = 2'b10
    } swp_ld_state_t;

endpackage : swp_pkg

// File: core/swp_serial_port.sv
// three-wire serial port and wiper registers of the six-channel pot
//
// Function
// RULE1: port counts as active only while port enable is high.
// RULE2: host starts each wiper-changing transaction with enable low to high.
// RULE3: while active, shift data input into 48-bit register on clock rise.
// RULE4: one bit per clock, least significant bit of each byte first.
// RULE5: host sends channel 1 first, then channels 2 to 6.
// RULE6: bits 0 to 5 of each byte are the 6-bit tap position.
// RULE7: code 11 in bits 7:6 keeps the wiper; otherwise position applies.
// RULE8: code 63 is the high terminal, code 0 the low terminal.
// RULE9: at power-up every wiper sits at position zero.
// RULE10: host clocks exactly 48 bits per device in each transaction.
// RULE11: cascade output is the last stage, channel 1 lsb goes out first.
// RULE12: cascade output is driven at all times.
// RULE13: with enable low, data input and serial clock are ignored.
// RULE14: daisy-chained, host clocks 48 bits times number of devices.
// RULE15: looped back, each clock moves the last bit into the first stage.
// RULE16: to read back, host releases data line and samples each clock.
// RULE17: enable falling ends transfer and applies register to wipers.
// RULE18: shift register keeps its contents between transactions.
`timescale 1ns/1ps
`default_nettype none

module swp_serial_port #(
    parameter int FIFO_DEPTH = swp_pkg::FIFO_DEPTH
) (
    // system clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      reset_n,
    // serial link, clocked by the host
    input  wire logic                      link_clk,
    input  wire logic                      port_en,
    input  wire logic                      ser_din,
    output logic                           ser_cout,
    // wiper side
    input  wire logic                      apply_hold,
    output logic [swp_pkg::CH_NUM*swp_pkg::POS_BITS-1:0] wiper_pos,
    output logic                           apply_busy,
    output logic                           frame_len_err
);

    localparam int SRB = swp_pkg::SR_BITS;
    localparam int WB  = swp_pkg::WORD_BITS;
    localparam int PB  = swp_pkg::POS_BITS;
    localparam int CB  = swp_pkg::CH_BITS;
    localparam int CN  = swp_pkg::CH_NUM;
    localparam int FW  = swp_pkg::FIFO_WIDTH;

    initial begin
        if (FIFO_DEPTH < CN) begin
            $error("swp_serial_port: FIFO_DEPTH below channel count");
        end
        if ((FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin
            $error("swp_serial_port: FIFO_DEPTH must be a power of two");
        end
        if (SRB != CN * WB) begin
            $error("swp_serial_port: shift register is not six words");
        end
        if (int'(swp_pkg::BIT_LAST) != SRB - 1) begin
            $error("swp_serial_port: bit counter end does not match frame");
        end
        if (swp_pkg::KEEP_LSB + 2 != WB) begin
            $error("swp_serial_port: keep code must sit at the word top");
        end
        if (CN > (1 << CB)) begin
            $error("swp_serial_port: channel index too narrow");
        end
        if (FW != CB + WB) begin
            $error("swp_serial_port: fifo word does not hold index and byte");
        end
    end

    function automatic logic [WB-1:0] word_sel(
        input logic [SRB-1:0] v,
        input logic [CB-1:0]  i
    );
        word_sel = v[i*WB +: WB];
    endfunction : word_sel

    function automatic logic is_keep(input logic [WB-1:0] w);
        is_keep = (w[swp_pkg::KEEP_LSB +: 2] == swp_pkg::KEEP_CODE);
    endfunction : is_keep

    ////////////////////////////////////////////////////////////////////////
    // link domain: shift register on the host's clock

    logic [SRB-1:0] sr_r;
    logic [SRB-1:0] sr_nxt;
    logic           tgl_r;
    logic           tgl_nxt;

    // RULE3 RULE13 gated shift
    // port_en meets its setup to link_clk at the pin, so it is not
    // resynchronised here; doing so would eat the first clock edges
    // RULE4 RULE15 new bit enters the top, last stage leaves
    assign sr_nxt  = port_en ? {ser_din, sr_r[SRB-1:1]} : sr_r;
    assign tgl_nxt = port_en ? !tgl_r : tgl_r;

    // RULE18 no clear other than reset
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            sr_r <= swp_pkg::SR_RESET;
        end else begin
            sr_r <= sr_nxt;
        end
    end

    // toggles once per accepted bit, so the count survives the crossing
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            tgl_r <= 1'b0;
        end else begin
            tgl_r <= tgl_nxt;
        end
    end

    // RULE11 RULE12 cascade is the last flop, whatever port_en does
    assign ser_cout = sr_r[0];

    ////////////////////////////////////////////////////////////////////////
    // crossing into the system domain

    logic [1:0] sync_s;
    logic       en_s;
    logic       tgl_s;
    logic       en_d_r;
    logic       tgl_d_r;
    logic       en_rise;
    logic       en_fall;
    logic       bit_ev;

    swp_sync #(
        .WIDTH    (2)
    ) u_sync (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .async_in ({tgl_r, port_en}),
        .sync_out (sync_s)
    );

    assign en_s    = sync_s[0];
    assign tgl_s   = sync_s[1];
    // RULE1 activity follows the enable level
    assign en_rise = en_s && !en_d_r;
    // RULE17 transfer ends on the enable's falling edge
    assign en_fall = en_d_r && !en_s;
    assign bit_ev  = tgl_s ^ tgl_d_r;

    // reset value matches the idle enable level: no false edge after reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            en_d_r <= 1'b0;
        end else begin
            en_d_r <= en_s;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tgl_d_r <= 1'b0;
        end else begin
            tgl_d_r <= tgl_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame length check and snapshot

    logic [5:0]     cnt_r;
    logic [5:0]     cnt_inc;
    logic [5:0]     cnt_nxt;
    logic           len_err_r;
    logic           len_err_nxt;
    logic [SRB-1:0] snap_r;
    logic [SRB-1:0] snap_nxt;

    // RULE10 count bits modulo one device frame
    assign cnt_inc = (cnt_r == swp_pkg::BIT_LAST) ? 6'h00 : cnt_r + 6'h01;
    assign cnt_nxt = en_rise ? (bit_ev ? 6'h01 : 6'h00)
                   : (bit_ev ? cnt_inc : cnt_r);
    assign len_err_nxt = en_fall ? (cnt_nxt != 6'h00) : len_err_r;

    // sr_r is frozen while port_en is low, and the enable synchroniser
    // guarantees it has been low for two edges before this capture
    assign snap_nxt = en_fall ? sr_r : snap_r;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 6'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            len_err_r <= 1'b0;
        end else begin
            len_err_r <= len_err_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            snap_r <= swp_pkg::SR_RESET;
        end else begin
            snap_r <= snap_nxt;
        end
    end

    assign frame_len_err = len_err_r;

    ////////////////////////////////////////////////////////////////////////
    // loader: pushes the six channel bytes into the fifo

    swp_pkg::swp_ld_state_t ld_r;
    swp_pkg::swp_ld_state_t ld_nxt;
    logic [CB-1:0]          idx_r;
    logic [CB-1:0]          idx_nxt;
    logic                   push_valid;
    logic                   push_ready;
    logic [FW-1:0]          push_data;
    logic                   push_last;

    assign push_valid = (ld_r == swp_pkg::SWP_LD_PUSH);
    assign push_data  = {idx_r, word_sel(snap_r, idx_r)};
    assign push_last  = (idx_r == CB'(CN - 1));

    // a new frame end restarts the load with the newest snapshot
    always_comb begin
        ld_nxt  = ld_r;
        idx_nxt = idx_r;
        unique case (ld_r)
            swp_pkg::SWP_LD_IDLE: begin
                ld_nxt = ld_r;
            end
            swp_pkg::SWP_LD_PUSH: begin
                if (push_ready) begin
                    idx_nxt = idx_r + CB'(1);
                    if (push_last) begin
                        ld_nxt = swp_pkg::SWP_LD_IDLE;
                    end
                end
            end
            default: begin
                ld_nxt = swp_pkg::SWP_LD_IDLE;
            end
        endcase
        if (en_fall) begin
            ld_nxt  = swp_pkg::SWP_LD_PUSH;
            idx_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ld_r <= swp_pkg::SWP_LD_IDLE;
        end else begin
            ld_r <= ld_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            idx_r <= '0;
        end else begin
            idx_r <= idx_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // buffer and wiper update

    logic          pop_valid;
    logic          pop_ready;
    logic [FW-1:0] pop_data;
    logic [CB-1:0] pop_ch;
    logic [WB-1:0] pop_word;
    logic          pop_take;

    swp_fifo #(
        .WIDTH     (FW),
        .DEPTH     (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_data)
    );

    // apply_hold lets the wiper side stall, backing up into the loader
    assign pop_ready = !apply_hold;
    assign pop_ch    = pop_data[FW-1 -: CB];
    assign pop_word  = pop_data[WB-1:0];
    // RULE7 keep code leaves the wiper alone
    assign pop_take  = pop_valid && pop_ready && !is_keep(pop_word);

    logic [CN*PB-1:0] wiper_r;
    logic [CN*PB-1:0] wiper_nxt;
    logic             busy_r;
    logic             busy_nxt;
    logic [CN-1:0]    ch_hit;

    // RULE6 RULE8 low six bits are the tap, 0 low end to 63 high end
    for (genvar c = 0; c < CN; c++) begin : g_wiper
        assign ch_hit[c] = pop_take && (pop_ch == CB'(c));
        assign wiper_nxt[c*PB +: PB] = ch_hit[c]
            ? pop_word[swp_pkg::POS_LSB +: PB]
            : wiper_r[c*PB +: PB];
    end

    assign busy_nxt = en_fall || (ld_nxt == swp_pkg::SWP_LD_PUSH)
                    || pop_valid;

    // RULE9 wipers start at the low terminal
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wiper_r <= {CN{swp_pkg::POS_RESET}};
        end else begin
            wiper_r <= wiper_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= busy_nxt;
        end
    end

    assign wiper_pos  = wiper_r;
    assign apply_busy = busy_r;

endmodule : swp_serial_port

`default_nettype wire

// File: core/swp_sync.sv
// two-flop level synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none

module swp_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    // levels in and out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    initial begin
        if (WIDTH < 1) begin
            $error("swp_sync: WIDTH must be at least 1");
        end
    end

    // meta_r is read by sync_r only
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule : swp_sync

`default_nettype wire
